// [bench/pfc_control_registers_monitor.sv]
/* Port checker for the PFC control bank.
   Assumes binding into the bank. */
`timescale 1ns/10ps
`include "pfc_defs.svh"
module pfc_control_registers_monitor
    import pfc_pkg::*;
#(
    parameter int ADDR_WIDTH = 18
)
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic [ADDR_WIDTH-1:0] awaddr,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic [31:0] wdata,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_WIDTH-1:0] araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    input wire logic rready,
    // Protection, PWM and sampling
    input wire logic overcurrent_comparator,
    input wire logic overcurrent_comparator_enable,
    input wire logic overcurrent_trip,
    input wire logic pwm_in,
    input wire logic pwm_pin,
    input wire logic pfc_period_tick,
    input wire logic line_voltage_sample_request,
    input average_s average
);
    localparam logic [ADDR_WIDTH-1:0] MAIN_ADDR = ADDR_WIDTH'(4 * `IDX_CONTROL_MAIN);

    // One clock for all checks
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_write_answer; awvalid && awready |=> bvalid; endproperty
    a_write_answer: assert property (p_write_answer) else $error("write response missing");
    property p_read_answer; arvalid && arready |=> rvalid; endproperty
    a_read_answer: assert property (p_read_answer) else $error("read response missing");
    property p_b_stands; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
    a_b_stands: assert property (p_b_stands) else $error("write response dropped");
    property p_r_stands; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
    a_r_stands: assert property (p_r_stands) else $error("read data dropped");
    property p_start_launch;
        awvalid && awready && awaddr == MAIN_ADDR && wdata[7] && wdata[0] |->
            ##[1:3] average.busy;
    endproperty
    a_start_launch: assert property (p_start_launch) else $error("start did not launch");
    property p_start_reads_zero;
        rvalid && !$past(rvalid) && $past(araddr) == MAIN_ADDR |-> rdata[7] == 1'b0;
    endproperty
    a_start_reads_zero: assert property (p_start_reads_zero) else $error("start set");
    property p_result_load; $rose(average.valid) |-> $past(average.busy); endproperty
    a_result_load: assert property (p_result_load) else $error("result without calculation");
    property p_trip_cause;
        $rose(overcurrent_trip) |-> $past(overcurrent_comparator_enable) &&
            $past(overcurrent_comparator, 4);
    endproperty
    a_trip_cause: assert property (p_trip_cause) else $error("trip without cause");
    property p_trip_low; overcurrent_trip |-> !pwm_pin; endproperty
    a_trip_low: assert property (p_trip_low) else $error("pwm high during trip");
    property p_pwm_source; pwm_pin |-> $past(pwm_in); endproperty
    a_pwm_source: assert property (p_pwm_source) else $error("pwm pin without source");
    property p_request_tick; line_voltage_sample_request |-> $past(pfc_period_tick); endproperty
    a_request_tick: assert property (p_request_tick) else $error("request off tick");
endmodule

bind pfc_control_registers pfc_control_registers_monitor #(.ADDR_WIDTH(ADDR_WIDTH))
    pfc_control_registers_monitor_i (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rvalid, .rready,
    .overcurrent_comparator, .overcurrent_comparator_enable, .overcurrent_trip, .pwm_in,
    .pwm_pin, .pfc_period_tick, .line_voltage_sample_request, .average);

// [bench/pfc_control_registers_test.sv]
/* Self-checking bench for the PFC control bank.
   Assumes the far-side model and the bound checker. */
`timescale 1ns/10ps
`include "pfc_defs.svh"
module pfc_control_registers_test
    import pfc_pkg::*;
;
    localparam int P = 8;
    localparam logic [17:0] A_MAIN = 18'(4 * `IDX_CONTROL_MAIN);
    localparam logic [17:0] A_CHAN = 18'(4 * `IDX_ADC_CHANNEL_SELECT);
    localparam logic [17:0] A_SAMP = 18'(4 * `IDX_CONTROL_SAMPLING);
    localparam logic [17:0] A_STAT = 18'(4 * `IDX_AVERAGE_STATUS);
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, comp, comp_en, trip, pwm_in, pwm_pin;
    logic tick, ovf, smp_valid, smp_req, seen;
    logic [17:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic [15:0] smp, base;
    logic [7:0] v, pimin;
    adc_select_s adc_select;
    average_s average;
    int error_cnt, checked, req_cnt, s0, seed;
    int flt[4] = '{0, 4, 8, 16};

    pfc_control_registers pfc_control_registers_i (.aclk, .aresetn, .awaddr, .awvalid,
        .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .overcurrent_comparator(comp),
        .overcurrent_comparator_enable(comp_en), .overcurrent_trip(trip), .pwm_in, .pwm_pin,
        .pfc_period_tick(tick), .internal_timer_overflow(ovf),
        .line_voltage_sample_valid(smp_valid), .line_voltage_sample(smp),
        .line_voltage_base(base), .line_voltage_sample_request(smp_req), .adc_select,
        .average, .voltage_pi_min_high(pimin));

    pfc_far_side_model #(.TICK_PERIOD(P)) pfc_far_side_model_i (.aclk, .aresetn,
        .line_voltage_sample_request(smp_req), .pwm_in,
        .pfc_period_tick(tick), .line_voltage_sample_valid(smp_valid),
        .line_voltage_sample(smp), .line_voltage_base(base));

    // Clock
    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // Sample request counter
    always @(posedge aclk)
        if (smp_req === 1'b1)
            req_cnt++;

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // Write, hangs left to the watchdog
    task automatic wr(input logic [17:0] a, input logic [7:0] dv, output logic [1:0] resp);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, dv};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(negedge aclk); while (awready !== 1'b1);
        @(posedge aclk);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(negedge aclk); while (bvalid !== 1'b1);
        resp = bresp;
        @(posedge aclk);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [17:0] a, output logic [31:0] dv, output logic [1:0] resp);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge aclk); while (arready !== 1'b1);
        @(posedge aclk);
        arvalid <= 1'b0;
        do @(negedge aclk); while (rvalid !== 1'b1);
        dv = rdata;
        resp = rresp;
        @(posedge aclk);
        rready <= 1'b0;
    endtask

    task automatic pulse(input int len);
        @(posedge aclk);
        comp <= 1'b1;
        cyc(len);
        comp <= 1'b0;
    endtask

    task automatic overflow();
        @(posedge aclk);
        ovf <= 1'b1;
        @(posedge aclk);
        ovf <= 1'b0;
    endtask

    task automatic watch_pwm();
        seen = 1'b0;
        repeat (3 * P)
        begin
            @(negedge aclk);
            seen = seen | (pwm_pin === 1'b1);
        end
    endtask

    task tally_and_finish();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Watchdog
    initial
    begin
        #200000;
        error_cnt++;
        tally_and_finish();
    end

    // Main sequence
    initial
    begin
        seed = 32'h609c;
        {aresetn, awvalid, wvalid, bready, arvalid, rready, comp, comp_en, ovf} = 9'h0;
        awaddr = 18'h0;
        araddr = 18'h0;
        wdata = 32'h0;
        wstrb = 4'hf;
        cyc(12);
        aresetn <= 1'b1;
        rd(A_MAIN, d, r);
        check("main reset", 32'h0, d);
        rd(A_CHAN, d, r);
        check("channel reset", 32'h65, d);
        rd(A_SAMP, d, r);
        check("sampling reset", 32'h0, d);
        check("adc_select reset", 32'h0ca, 32'(adc_select));
        rd(18'h0, d, r);
        check("unmapped rresp", 32'h2, 32'(r));
        wr(A_STAT, 8'hff, r);
        check("status write bresp", 32'h2, 32'(r));
        repeat (6)
        begin
            v = {4'($unsigned($random(seed)) % 14), 4'($unsigned($random(seed)) % 14)};
            wr(A_CHAN, v, r);
            rd(A_CHAN, d, r);
            check("channel readback", 32'(v), d);
            check("adc_select", 32'({v, 1'b0}), 32'(adc_select));
        end
        wr(A_CHAN, 8'h65, r);
        wr(A_SAMP, 8'ha5, r);
        check("pi min high", 32'ha5, 32'(pimin));
        wr(A_MAIN, 8'h11, r);
        wr(A_SAMP, 8'h01, r);
        check("pi min kept", 32'ha5, 32'(pimin));
        rd(A_SAMP, d, r);
        check("sampling readback", 32'h01, d);
        for (int c = 0; c < 4; c++)
        begin
            wr(A_SAMP, {2'(c), 6'h01}, r);
            cyc(16 * P);
            do @(negedge aclk); while (tick !== 1'b1);
            @(negedge aclk);
            s0 = req_cnt;
            repeat (16 * P) @(negedge aclk);
            check("sample requests", 32'(16 >> c), 32'(req_cnt - s0));
        end
        wr(A_SAMP, 8'h01, r);
        watch_pwm();
        check("pwm withheld", 32'h0, 32'(seen));
        wr(A_MAIN, 8'h17, r);
        check("offset to voltage", 32'h1, 32'(adc_select.offset_to_voltage));
        watch_pwm();
        check("pwm routed", 32'h1, 32'(seen));
        wr(A_MAIN, 8'h13, r);
        check("offset to current", 32'h0, 32'(adc_select.offset_to_voltage));
        pulse(20);
        cyc(6);
        check("trip while disabled", 32'h0, 32'(trip));
        comp_en <= 1'b1;
        for (int c = 0; c < 4; c++)
        begin
            wr(A_MAIN, 8'h11, r);
            wr(A_MAIN, {1'b0, 2'(c), 5'h13}, r);
            if (flt[c] > 1)
            begin
                pulse(flt[c] - 1);
                cyc(flt[c] + 6);
                check("short pulse", 32'h0, 32'(trip));
            end
            pulse(flt[c] + 2);
            cyc(3);
            check("trip", 32'h1, 32'(trip));
            check("pwm forced low", 32'h0, 32'(pwm_pin));
            cyc(flt[c] + 20);
            check("trip latched", 32'h1, 32'(trip));
        end
        wr(A_MAIN, 8'h11, r);
        wr(A_MAIN, 8'h3b, r);
        pulse(8);
        cyc(1);
        check("limit trip", 32'h1, 32'(trip));
        cyc(12);
        check("limit restore", 32'h0, 32'(trip));
        comp_en <= 1'b0;
        wr(A_MAIN, 8'h11, r);
        cyc(40);
        check("zero start idle", 32'h0, 32'(average.busy));
        wr(A_MAIN, 8'h91, r);
        rd(A_MAIN, d, r);
        check("start reads zero", 32'h11, d);
        check("start busy", 32'h1, 32'(average.busy));
        cyc(400);
        overflow();
        cyc(2);
        check("overflow busy", 32'h1, 32'(average.busy));
        cyc(40);
        rd(A_STAT, d, r);
        check("average result", 32'h11234, d);
        wr(A_SAMP, 8'h1f, r);
        cyc(400);
        overflow();
        cyc(40);
        check("too few samples", 32'h0, 32'(average.valid));
        tally_and_finish();
    end
endmodule

// [bench/pfc_far_side_model.sv]
/* PWM core, period timer and line-voltage ADC seen from the bank.
   Assumes the bank's clock; the ADC answers two cycles after a request. */
`timescale 1ns/10ps
module pfc_far_side_model #(
    parameter int TICK_PERIOD = 8,
    parameter logic [15:0] SAMPLE_VALUE = 16'h1234
)
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // ADC request
    input wire logic line_voltage_sample_request,
    // Core and ADC outputs
    output logic pwm_in,
    output logic pfc_period_tick,
    output logic line_voltage_sample_valid,
    output logic [15:0] line_voltage_sample,
    output logic [15:0] line_voltage_base
);
    int cnt;
    logic [1:0] pend;

    // Period timer with tick and half-period PWM
    always_ff @(posedge aclk)
    begin
        cnt <= (!aresetn || cnt == TICK_PERIOD - 1) ? 0 : cnt + 1;
        pfc_period_tick <= aresetn && cnt == TICK_PERIOD - 1;
        pwm_in <= aresetn && cnt < TICK_PERIOD / 2;
        pend <= aresetn ? {pend[0], line_voltage_sample_request} : 2'h0;
    end

    // Bus shows the inverse value while no conversion is offered
    assign line_voltage_sample_valid = pend[1];
    assign line_voltage_sample = pend[1] ? SAMPLE_VALUE : ~SAMPLE_VALUE;
    assign line_voltage_base = 16'h4000;
endmodule

// [hw/pfc_control_registers.sv]
/*
 * PFC control register bank with over-current gating, averaging and sample pacing.
 * Assumes an AXI4-Lite master on aclk, a same-clock PWM core and sampler, and an
 * asynchronous over-current comparator pin.
 */
// Function
// - Start bit launches averaging, self-clears next clock
// - Writing zero to start bit does nothing
// - Finished average loads rectified average value
// - Filter rejects pulses shorter than 0/4/8/16 clocks
// - Hardware averages per half period unless disabled
// - Timer overflow starts averaging when hardware disabled
// - Enabled over-current event forces outputs off
// - Cycle limit restores output after over-current clears
// - Offset select steers offset to current/voltage
// - Output enable passes PWM to its pin
// - Sampling register acts only while module enabled
// - Disabled module: address holds PI minimum high
// - Voltage sampled every 1/2/4/8 PFC periods
// - Threshold is base/8 or base/16
// - Average valid only with count >= minimum*32
// - Current channel field selects channels 0..13
// - Lower nibble selects voltage sampling channel
// - Filtered comparator high forces PWM low while comparator enable is high
`timescale 1ns/10ps
module pfc_control_registers
    import pfc_pkg::*;
#(
    parameter int ADDR_WIDTH = 18,
    parameter int SAMPLE_WIDTH = 16
)
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [ADDR_WIDTH-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [ADDR_WIDTH-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Over-current comparator
    input wire logic overcurrent_comparator,
    input wire logic overcurrent_comparator_enable,
    output logic overcurrent_trip,
    // PWM path
    input wire logic pwm_in,
    output logic pwm_pin,
    // Sampling
    input wire logic pfc_period_tick,
    input wire logic internal_timer_overflow,
    input wire logic line_voltage_sample_valid,
    input wire logic [SAMPLE_WIDTH-1:0] line_voltage_sample,
    input wire logic [SAMPLE_WIDTH-1:0] line_voltage_base,
    output logic line_voltage_sample_request,
    output adc_select_s adc_select,
    output average_s average,
    output logic [7:0] voltage_pi_min_high
);

    // Register index from a byte address
    function automatic logic [15:0] reg_index(input logic [ADDR_WIDTH-1:0] addr);
        reg_index = 16'(addr >> 2);
    endfunction

    // Filter width in clocks for a filter code
    function automatic logic [4:0] filter_clocks(input logic [1:0] code);
        case (code)
            2'h1: filter_clocks = `FILTER_CLOCKS_01;
            2'h2: filter_clocks = `FILTER_CLOCKS_10;
            2'h3: filter_clocks = `FILTER_CLOCKS_11;
            default: filter_clocks = 5'h00;
        endcase
    endfunction

    control_main_s control_main;
    logic average_start_bit;
    logic [7:0] pfc_adc_channel_select;
    logic [7:0] pfc_control_sampling;
    logic [15:0] write_index;
    logic [15:0] read_index;
    logic [1:0] line_voltage_sample_period;
    logic average_period_threshold;
    logic [4:0] minimum_sample_count;

    assign line_voltage_sample_period = pfc_control_sampling[7:6];
    assign average_period_threshold = pfc_control_sampling[5];
    assign minimum_sample_count = pfc_control_sampling[4:0];

    // Write taken with address and data together
    assign awready = awvalid && wvalid && !bvalid;
    assign wready = awready;
    assign write_index = reg_index(awaddr);
    assign read_index = reg_index(araddr);
    assign arready = !rvalid;

    // Write response
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid <= 1'b0;
            bresp <= 2'h0;
        end
        else if (awready)
        begin
            bvalid <= 1'b1;
            bresp <= (write_index == `IDX_CONTROL_MAIN ||
                      write_index == `IDX_ADC_CHANNEL_SELECT ||
                      write_index == `IDX_CONTROL_SAMPLING) ? 2'h0 : 2'h2;
        end
        else if (bready)
            bvalid <= 1'b0;
    end

    // Main control register and self-clearing start bit
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            control_main <= control_main_s'(`RST_CONTROL_MAIN);
            average_start_bit <= 1'b0;
        end
        else
        begin
            average_start_bit <= 1'b0;
            if (awready && wstrb[0] && write_index == `IDX_CONTROL_MAIN)
            begin
                control_main <= control_main_s'(wdata[6:0]);
                average_start_bit <= wdata[`BIT_AVG_START];
            end
        end
    end

    // Channel select and shared sampling / PI minimum
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pfc_adc_channel_select <= `RST_ADC_CHANNEL_SELECT;
            pfc_control_sampling <= `RST_CONTROL_SAMPLING;
            voltage_pi_min_high <= `RST_PI_MIN_HIGH;
        end
        else if (awready && wstrb[0])
        begin
            if (write_index == `IDX_ADC_CHANNEL_SELECT)
                pfc_adc_channel_select <= wdata[7:0];
            if (write_index == `IDX_CONTROL_SAMPLING && control_main.module_enable)
                pfc_control_sampling <= wdata[7:0];
            if (write_index == `IDX_CONTROL_SAMPLING && !control_main.module_enable)
                voltage_pi_min_high <= wdata[7:0];
        end
    end

    // Read channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= 2'h0;
        end
        else if (arvalid && arready)
        begin
            rvalid <= 1'b1;
            rresp <= 2'h0;
            case (read_index)
                `IDX_CONTROL_MAIN: rdata <= {25'h0, control_main};
                `IDX_ADC_CHANNEL_SELECT: rdata <= {24'h0, pfc_adc_channel_select};
                `IDX_CONTROL_SAMPLING: rdata <= {24'h0, control_main.module_enable ?
                    pfc_control_sampling : voltage_pi_min_high};
                `IDX_AVERAGE_STATUS: rdata <= {14'h0, average};
                default:
                begin
                    rdata <= 32'h0;
                    rresp <= 2'h2;
                end
            endcase
        end
        else if (rready)
            rvalid <= 1'b0;
    end

    // ADC steering
    always_comb
    begin
        adc_select.current_channel_select = pfc_adc_channel_select[7:4];
        adc_select.voltage_channel_select = pfc_adc_channel_select[3:0];
        adc_select.offset_to_voltage = control_main.offset_channel_select;
    end

    // Comparator pin synchroniser and noise filter
    logic cmp_meta;
    logic cmp_sync;
    logic cmp_filtered;
    logic [4:0] filter_count;
    logic [4:0] filter_len;

    assign filter_len = filter_clocks(control_main.overcurrent_filter_select);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cmp_meta <= 1'b0;
            cmp_sync <= 1'b0;
        end
        else
        begin
            cmp_meta <= overcurrent_comparator;
            cmp_sync <= cmp_meta;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cmp_filtered <= 1'b0;
            filter_count <= 5'h00;
        end
        else if (filter_len == 5'h00 || cmp_sync == cmp_filtered ||
            filter_count + 5'h01 >= filter_len)
        begin
            cmp_filtered <= cmp_sync;
            filter_count <= 5'h00;
        end
        else
        begin
            filter_count <= filter_count + 5'h01;
        end
    end

    // Over-current trip, latched or cycle-limited
    logic overcurrent_event;
    assign overcurrent_event = overcurrent_comparator_enable && cmp_filtered;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            overcurrent_trip <= 1'b0;
        else if (overcurrent_event)
            overcurrent_trip <= 1'b1;
        else if (control_main.cycle_limit_enable)
            overcurrent_trip <= 1'b0;
        else if (!control_main.pwm_output_enable || !control_main.module_enable)
            overcurrent_trip <= 1'b0; // Disabling the output rearms protection
    end

    // PWM pin gating
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            pwm_pin <= 1'b0;
        else
            pwm_pin <= pwm_in && control_main.module_enable &&
                control_main.pwm_output_enable &&
                !overcurrent_trip && !overcurrent_event;
    end

    // Line voltage sample pacing in PFC periods
    logic [2:0] period_count;
    logic [2:0] period_last;
    assign period_last = 3'((4'h1 << line_voltage_sample_period) - 4'h1);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            period_count <= 3'h0;
            line_voltage_sample_request <= 1'b0;
        end
        else
        begin
            line_voltage_sample_request <= 1'b0;
            if (!control_main.module_enable)
                period_count <= 3'h0;
            else if (pfc_period_tick && period_count >= period_last)
            begin
                period_count <= 3'h0;
                line_voltage_sample_request <= 1'b1;
            end
            else if (pfc_period_tick)
                period_count <= period_count + 3'h1;
        end
    end

    // Period boundary: sample rises through the threshold
    logic [SAMPLE_WIDTH-1:0] threshold;
    logic [SAMPLE_WIDTH-1:0] previous_sample;
    logic boundary;
    logic trigger;
    assign threshold = average_period_threshold ?
        (line_voltage_base >> 3) : (line_voltage_base >> 4);
    assign boundary = line_voltage_sample_valid && line_voltage_sample > threshold &&
        previous_sample <= threshold;
    assign trigger = control_main.module_enable &&
        ((boundary && !control_main.hardware_average_disable) ||
        (internal_timer_overflow && control_main.hardware_average_disable) ||
        average_start_bit);

    // Accumulation of samples within one period
    logic [31:0] sample_sum;
    logic [15:0] sample_count;
    logic enough_samples;
    assign enough_samples = sample_count != 16'h0 &&
        sample_count >= (16'(minimum_sample_count) << `MIN_COUNT_SCALE);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            previous_sample <= '0;
            sample_sum <= 32'h0;
            sample_count <= 16'h0;
        end
        else if (!control_main.module_enable)
        begin
            sample_sum <= 32'h0;
            sample_count <= 16'h0;
        end
        else
        begin
            if (line_voltage_sample_valid)
                previous_sample <= line_voltage_sample;
            if (trigger)
            begin
                sample_sum <= line_voltage_sample_valid ? 32'(line_voltage_sample) : 32'h0;
                sample_count <= line_voltage_sample_valid ? 16'h1 : 16'h0;
            end
            else if (line_voltage_sample_valid && sample_count != 16'hffff)
            begin
                sample_sum <= sample_sum + 32'(line_voltage_sample);
                sample_count <= sample_count + 16'h1;
            end
        end
    end

    // Restoring divider producing the average
    average_state_e avg_state;
    logic [31:0] quotient;
    logic [16:0] remainder;
    logic [15:0] divisor;
    logic [5:0] divide_step;
    logic [16:0] trial;
    assign trial = {remainder[15:0], quotient[31]};
    logic fits;
    assign fits = trial >= {1'b0, divisor}; // Quotient bit of this step

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            avg_state <= avg_idle;
            quotient <= 32'h0;
            remainder <= 17'h0;
            divisor <= 16'h0;
            divide_step <= 6'h0;
            average <= '0;
        end
        else
        begin
            case (avg_state)
                avg_idle:
                begin
                    if (trigger && enough_samples)
                    begin
                        quotient <= sample_sum;
                        remainder <= 17'h0;
                        divisor <= sample_count;
                        divide_step <= 6'h0;
                        average.busy <= 1'b1;
                        avg_state <= avg_divide;
                    end
                    else if (trigger)
                        average.valid <= 1'b0;
                end
                avg_divide:
                begin
                    remainder <= fits ? trial - {1'b0, divisor} : trial;
                    quotient <= {quotient[30:0], fits};
                    divide_step <= divide_step + 6'h1;
                    if (divide_step == `DIVIDE_STEPS - 6'h1)
                    begin
                        average.rectified_average_voltage <= {quotient[14:0], fits};
                        average.valid <= 1'b1;
                        average.busy <= 1'b0;
                        avg_state <= avg_idle;
                    end
                end
                default: avg_state <= avg_idle;
            endcase
        end
    end

endmodule

// [hw/pfc_defs.svh]
/*
 * Indices, fields, resets and counts of the PFC control bank.
 * Assumes inclusion by its bare name from the package and the bench modules.
 */
`ifndef PFC_DEFS_SVH
`define PFC_DEFS_SVH

// Register indices; byte address is four times the index
`define IDX_CONTROL_MAIN 16'h40e0
`define IDX_ADC_CHANNEL_SELECT 16'h40e1
`define IDX_CONTROL_SAMPLING 16'h40f2
`define IDX_AVERAGE_STATUS 16'h40f4

// Main control fields
`define BIT_AVG_START 7
`define BIT_FILTER_HI 6
`define BIT_FILTER_LO 5
`define BIT_HW_AVG_DIS 4
`define BIT_CYCLE_LIMIT 3
`define BIT_OFFSET_SEL 2
`define BIT_OUTPUT_EN 1
`define BIT_MODULE_EN 0

// Reset values
`define RST_CONTROL_MAIN 8'h00
`define RST_ADC_CHANNEL_SELECT 8'h65
`define RST_CONTROL_SAMPLING 8'h00
`define RST_PI_MIN_HIGH 8'h00

// Filter widths, count scale and divider steps
`define FILTER_CLOCKS_01 5'h04
`define FILTER_CLOCKS_10 5'h08
`define FILTER_CLOCKS_11 5'h10
`define MIN_COUNT_SCALE 5
`define DIVIDE_STEPS 6'h20

`endif

// [hw/pfc_pkg.sv]
/*
 * Types shared by the PFC control bank and its users.
 * Assumes pfc_defs.svh is on the include path.
 */
package pfc_pkg;
    `include "pfc_defs.svh"

    // Main control register contents, start bit excluded
    typedef struct packed {
        logic [1:0] overcurrent_filter_select;
        logic hardware_average_disable;
        logic cycle_limit_enable;
        logic offset_channel_select;
        logic pwm_output_enable;
        logic module_enable;
    } control_main_s;

    // ADC steering handed to the sampling logic
    typedef struct packed {
        logic [3:0] current_channel_select;
        logic [3:0] voltage_channel_select;
        logic offset_to_voltage;
    } adc_select_s;

    // Average result as software sees it
    typedef struct packed {
        logic busy;
        logic valid;
        logic [15:0] rectified_average_voltage;
    } average_s;

    typedef enum logic {avg_idle, avg_divide} average_state_e;
endpackage
